// File: hw/acm_amp_ctrl.sv
`timescale 1ns/100ps
module acm_amp_ctrl #(
    parameter longint unsigned SETTLE_CYCLES = acm_pkg::SETTLE_CYCLES_DEFAULT
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [acm_pkg::ADR_W-1:0] wb_adr_in,
    input wire logic [acm_pkg::SEL_W-1:0] wb_sel_in,
    input wire logic [acm_pkg::DAT_W-1:0] wb_dat_in,
    output logic [acm_pkg::DAT_W-1:0] wb_dat_out,
    output logic wb_ack_out,
    // pins
    input wire logic headphone_detect_pin_in,
    input wire logic alert_level_in,
    // amplifier controls
    output logic bias_on_out,
    output logic unity_buffer_out,
    output logic amp_ready_out,
    output logic bridge_enable_out,
    output logic speaker_mute_out,
    output logic dock_mute_out,
    output logic single_ended_out,
    output logic gain_external_out,
    output logic volume_active_out,
    output logic [acm_pkg::VOLUME_LEVEL_W-1:0] volume_level_out
);

    localparam longint unsigned SETTLE_LAST_WIDE = SETTLE_CYCLES - 64'd1;
    localparam logic [acm_pkg::SETTLE_CNT_W-1:0] SETTLE_LAST =
        SETTLE_LAST_WIDE[acm_pkg::SETTLE_CNT_W-1:0];

    typedef struct packed {
        // control bits
        logic power_down_ctl;
        logic silence_ctl;
        logic volume_enable_ctl;
        logic gain_source_sel;
        logic headphone_ctl;
        logic [acm_pkg::VOLUME_LEVEL_W-1:0] volume_level;
        // power sequencing
        acm_pkg::acm_pwr_t pwr;
        logic [acm_pkg::SETTLE_CNT_W-1:0] settle_cnt;
        // bus
        logic ack;
        logic [acm_pkg::DAT_W-1:0] rdata;
        // outputs
        logic bias_on;
        logic unity_buffer;
        logic amp_ready;
        logic bridge_enable;
        logic speaker_mute;
        logic dock_mute;
        logic single_ended;
        logic gain_external;
        logic volume_active;
        logic [acm_pkg::VOLUME_LEVEL_W-1:0] volume_out;
    } acm_state_t;

    acm_state_t st_reg;
    acm_state_t st_next;

    logic hp_pin_level;
    logic alert_pin_level;

    // address match on a word offset
    function automatic logic acm_hit(input logic [acm_pkg::ADR_W-1:0] adr,
                                     input logic [acm_pkg::ADR_W-1:0] off);
        acm_hit = (adr[acm_pkg::ADR_W-1:2] == off[acm_pkg::ADR_W-1:2]);
    endfunction

    // pin synchronisers
    acm_pin_sync u_hp_sync (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(headphone_detect_pin_in),
        .level_out(hp_pin_level)
    );

    acm_pin_sync u_alert_sync (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(alert_level_in),
        .level_out(alert_pin_level)
    );

    always_comb begin
        logic req;
        logic wr_commit;
        logic alert_seen;
        logic se_mode;
        logic [acm_pkg::DAT_W-1:0] rd;
        req = 1'b0;
        wr_commit = 1'b0;
        alert_seen = 1'b0;
        se_mode = 1'b0;
        rd = '0;
        st_next = st_reg;

        // bus handshake: ack one cycle after request, dropped after one cycle
        req = wb_cyc_in && wb_stb_in;
        st_next.ack = req && !st_reg.ack;
        // write lands on the edge where the master sees ack
        wr_commit = req && st_reg.ack && wb_we_in && wb_sel_in[0];

        if (wr_commit && acm_hit(wb_adr_in, acm_pkg::CTRL_OFF)) begin
            st_next.power_down_ctl = wb_dat_in[acm_pkg::POWER_DOWN_CTL_POS];
            st_next.silence_ctl = wb_dat_in[acm_pkg::SILENCE_CTL_POS];
            st_next.volume_enable_ctl = wb_dat_in[acm_pkg::VOLUME_ENABLE_CTL_POS];
            st_next.gain_source_sel = wb_dat_in[acm_pkg::GAIN_SOURCE_SEL_POS];
            st_next.headphone_ctl = wb_dat_in[acm_pkg::HEADPHONE_CTL_POS];
        end
        if (wr_commit && acm_hit(wb_adr_in, acm_pkg::VOL_OFF)) begin
            st_next.volume_level =
                wb_dat_in[acm_pkg::VOLUME_LEVEL_POS +: acm_pkg::VOLUME_LEVEL_W];
        end

        // read data, unmapped reads as zero
        if (acm_hit(wb_adr_in, acm_pkg::CTRL_OFF)) begin
            rd[acm_pkg::POWER_DOWN_CTL_POS] = st_reg.power_down_ctl;
            rd[acm_pkg::SILENCE_CTL_POS] = st_reg.silence_ctl;
            rd[acm_pkg::VOLUME_ENABLE_CTL_POS] = st_reg.volume_enable_ctl;
            rd[acm_pkg::GAIN_SOURCE_SEL_POS] = st_reg.gain_source_sel;
            rd[acm_pkg::HEADPHONE_CTL_POS] = st_reg.headphone_ctl;
        end else if (acm_hit(wb_adr_in, acm_pkg::VOL_OFF)) begin
            rd[acm_pkg::VOLUME_LEVEL_POS +: acm_pkg::VOLUME_LEVEL_W] = st_reg.volume_level;
        end else if (acm_hit(wb_adr_in, acm_pkg::STAT_OFF)) begin
            rd[acm_pkg::STAT_READY_POS] = st_reg.amp_ready;
            rd[acm_pkg::STAT_UNITY_POS] = st_reg.unity_buffer;
            rd[acm_pkg::STAT_ALERT_POS] = alert_pin_level;
            rd[acm_pkg::STAT_HP_PIN_POS] = hp_pin_level;
            rd[acm_pkg::STAT_SINGLE_ENDED_POS] = st_reg.single_ended;
            rd[acm_pkg::STAT_BRIDGE_POS] = st_reg.bridge_enable;
            rd[acm_pkg::STAT_SPK_MUTE_POS] = st_reg.speaker_mute;
        end
        if (req && !st_reg.ack) begin
            st_next.rdata = rd;
        end else if (!req) begin
            st_next.rdata = '0;
        end

        // power sequencing
        unique case (st_reg.pwr)
            acm_pkg::PWR_OFF: begin
                st_next.settle_cnt = '0;
                if (st_reg.power_down_ctl) begin
                    st_next.pwr = acm_pkg::PWR_SETTLE;
                end
            end
            acm_pkg::PWR_SETTLE: begin
                if (!st_reg.power_down_ctl) begin
                    st_next.pwr = acm_pkg::PWR_OFF;
                    st_next.settle_cnt = '0;
                end else if (st_reg.settle_cnt == SETTLE_LAST) begin
                    st_next.pwr = acm_pkg::PWR_ACTIVE;
                    st_next.settle_cnt = '0;
                end else begin
                    st_next.settle_cnt = st_reg.settle_cnt + 1'b1;
                end
            end
            acm_pkg::PWR_ACTIVE: begin
                if (!st_reg.power_down_ctl) begin
                    st_next.pwr = acm_pkg::PWR_OFF;
                end
            end
            default: begin
                st_next.pwr = acm_pkg::PWR_OFF;
                st_next.settle_cnt = '0;
            end
        endcase

        // alert detection only meaningful with bias on
        alert_seen = alert_pin_level && (st_reg.pwr != acm_pkg::PWR_OFF);
        // pin high forces single-ended whatever the bit says
        se_mode = hp_pin_level ? 1'b1 : st_reg.headphone_ctl;

        st_next.bias_on = (st_reg.pwr != acm_pkg::PWR_OFF);
        st_next.unity_buffer = (st_reg.pwr == acm_pkg::PWR_SETTLE);
        st_next.amp_ready = (st_reg.pwr == acm_pkg::PWR_ACTIVE);
        st_next.bridge_enable = (st_reg.pwr != acm_pkg::PWR_OFF)
            && (!st_reg.silence_ctl || alert_seen);
        st_next.speaker_mute = st_reg.silence_ctl && !alert_seen;
        st_next.dock_mute = st_reg.silence_ctl;
        st_next.single_ended = se_mode;
        st_next.gain_external = st_reg.gain_source_sel;
        st_next.volume_active = st_reg.volume_enable_ctl;
        if (st_reg.volume_enable_ctl) begin
            st_next.volume_out = st_reg.volume_level;
        end else begin
            st_next.volume_out = acm_pkg::FIXED_GAIN_LEVEL;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
            st_reg.volume_out <= acm_pkg::FIXED_GAIN_LEVEL;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flops
    assign wb_ack_out = st_reg.ack;
    assign wb_dat_out = st_reg.rdata;
    assign bias_on_out = st_reg.bias_on;
    assign unity_buffer_out = st_reg.unity_buffer;
    assign amp_ready_out = st_reg.amp_ready;
    assign bridge_enable_out = st_reg.bridge_enable;
    assign speaker_mute_out = st_reg.speaker_mute;
    assign dock_mute_out = st_reg.dock_mute;
    assign single_ended_out = st_reg.single_ended;
    assign gain_external_out = st_reg.gain_external;
    assign volume_active_out = st_reg.volume_active;
    assign volume_level_out = st_reg.volume_out;

endmodule

// File: hw/acm_pkg.sv
package acm_pkg;

    // bus geometry
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;

    // register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] VOL_OFF = 8'h04;
    localparam logic [7:0] STAT_OFF = 8'h08;

    // control word field positions
    localparam int POWER_DOWN_CTL_POS = 0;
    localparam int SILENCE_CTL_POS = 1;
    localparam int VOLUME_ENABLE_CTL_POS = 2;
    localparam int GAIN_SOURCE_SEL_POS = 3;
    localparam int HEADPHONE_CTL_POS = 4;

    // volume word field
    localparam int VOLUME_LEVEL_POS = 0;
    localparam int VOLUME_LEVEL_W = 5;

    // status word field positions
    localparam int STAT_READY_POS = 0;
    localparam int STAT_UNITY_POS = 1;
    localparam int STAT_ALERT_POS = 2;
    localparam int STAT_HP_PIN_POS = 3;
    localparam int STAT_SINGLE_ENDED_POS = 4;
    localparam int STAT_BRIDGE_POS = 5;
    localparam int STAT_SPK_MUTE_POS = 6;

    // values after reset
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [4:0] VOLUME_LEVEL_RESET = 5'h00;
    // level driven while volume control is bypassed: top step, no attenuation
    localparam logic [4:0] FIXED_GAIN_LEVEL = 5'h1f;

    // turn-on settling: linear in the reference capacitor
    localparam int CLK_PERIOD_NS = 4;
    localparam int TON_MIN_MS = 2;
    localparam int TON_MIN_CAP_NF = 10;
    localparam int TON_MAX_MS = 200;
    localparam int TON_MAX_CAP_NF = 1000;
    localparam int REF_CAP_NF_DEFAULT = 10;
    localparam int TON_NS_PER_NF = (TON_MIN_MS * 1000000) / TON_MIN_CAP_NF;
    localparam longint SETTLE_CYCLES_DEFAULT =
        (longint'(REF_CAP_NF_DEFAULT) * TON_NS_PER_NF + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CNT_W = 32;

    // power sequencing states
    typedef enum logic [1:0] {
        PWR_OFF = 2'b00,
        PWR_SETTLE = 2'b01,
        PWR_ACTIVE = 2'b10
    } acm_pwr_t;

endpackage

// File: hw/acm_pin_sync.sv
`timescale 1ns/100ps
module acm_pin_sync (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // asynchronous pin
    input wire logic pin_in,
    // filtered level
    output logic level_out
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } acm_sync_st_t;

    acm_sync_st_t st_reg;
    acm_sync_st_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.s1 = pin_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        // change accepted once second and third stages agree
        if (st_reg.s2 == st_reg.s3) begin
            st_next.level = st_reg.s3;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.level;

endmodule

// File: verif/acm_amp_ctrl_asserts.sv
`timescale 1ns/100ps
module acm_amp_ctrl_asserts (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // bus handshake
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_ack_out,
    // pin and amplifier controls
    input wire logic headphone_detect_pin_in,
    input wire logic bias_on_out,
    input wire logic unity_buffer_out,
    input wire logic amp_ready_out,
    input wire logic bridge_enable_out,
    input wire logic speaker_mute_out,
    input wire logic dock_mute_out,
    input wire logic single_ended_out,
    input wire logic volume_active_out,
    input wire logic [acm_pkg::VOLUME_LEVEL_W-1:0] volume_level_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_ack; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out; endproperty
    property p_ack_one; wb_ack_out |=> !wb_ack_out; endproperty
    property p_ready; amp_ready_out |-> bias_on_out && !unity_buffer_out; endproperty
    property p_unity; $rose(amp_ready_out) |-> $past(unity_buffer_out); endproperty
    property p_fixed;
        !volume_active_out |-> volume_level_out == acm_pkg::FIXED_GAIN_LEVEL;
    endproperty
    property p_dock; speaker_mute_out |-> dock_mute_out; endproperty
    property p_bridge; bridge_enable_out |-> bias_on_out; endproperty
    property p_alert;
        bias_on_out && dock_mute_out && !speaker_mute_out |-> bridge_enable_out;
    endproperty
    property p_hp; headphone_detect_pin_in [*8] |-> single_ended_out; endproperty
    a_ack: assert property (p_ack) else $error("no ack after request");
    a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
    a_ready: assert property (p_ready) else $error("ready outside run state");
    a_unity: assert property (p_unity) else $error("ready without unity phase");
    a_fixed: assert property (p_fixed) else $error("fixed gain level wrong");
    a_dock: assert property (p_dock) else $error("speaker muted, dock not");
    a_bridge: assert property (p_bridge) else $error("bridge on in shutdown");
    a_alert: assert property (p_alert) else $error("alert blocked by mute");
    a_hp: assert property (p_hp) else $error("pin did not force single ended");
    c_ready: cover property ($rose(amp_ready_out));
    c_alert: cover property (dock_mute_out && bridge_enable_out);
    c_se: cover property (single_ended_out && headphone_detect_pin_in);
endmodule
bind acm_amp_ctrl acm_amp_ctrl_asserts chk_u (.*);

// File: verif/acm_host_model.sv
`timescale 1ns/100ps
module acm_host_model (
    // clock
    input wire logic clk_in,
    // slave answer
    input wire logic ack_in,
    input wire logic [31:0] rdat_in,
    // request
    output logic cyc_out,
    output logic stb_out,
    output logic we_out,
    output logic [7:0] adr_out,
    output logic [3:0] sel_out,
    output logic [31:0] dat_out
);
    initial begin
        {cyc_out, stb_out, we_out, adr_out, sel_out, dat_out} = '0;
    end
    // one whole write or read; value applies only at the ack edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] q, output logic ok);
        int n;
        @(posedge clk_in);
        cyc_out <= 1'b1;
        stb_out <= 1'b1;
        we_out <= w;
        adr_out <= a;
        dat_out <= d;
        sel_out <= s;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (ack_in !== 1'b1 && n < 50);
        ok = (ack_in === 1'b1);
        q = rdat_in;
        cyc_out <= 1'b0;
        stb_out <= 1'b0;
        we_out <= 1'b0;
        dat_out <= ~d;
        adr_out <= ~a;
    endtask
endmodule

// File: verif/acm_amp_ctrl_tb.sv
`timescale 1ns/100ps
module acm_amp_ctrl_tb;
    logic sys_clk_in = 1'b0, rst_n_in = 1'b0, hp = 1'b0, alert = 1'b0;
    logic cyc, stb, we, ack, bias, unity, rdy, brg, smute, dmute, se, gext, vact;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [4:0] vlev;
    int err_count = 0, n_tests = 0;
    localparam int SETTLE_N = 8;
    always #2 sys_clk_in = ~sys_clk_in;
    acm_host_model host_u (.clk_in(sys_clk_in), .ack_in(ack), .rdat_in(rdat), .cyc_out(cyc),
        .stb_out(stb), .we_out(we), .adr_out(adr), .sel_out(sel), .dat_out(wdat));
    acm_amp_ctrl #(.SETTLE_CYCLES(SETTLE_N)) dut_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
        .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .headphone_detect_pin_in(hp),
        .alert_level_in(alert), .bias_on_out(bias), .unity_buffer_out(unity),
        .amp_ready_out(rdy), .bridge_enable_out(brg), .speaker_mute_out(smute),
        .dock_mute_out(dmute), .single_ended_out(se), .gain_external_out(gext),
        .volume_active_out(vact), .volume_level_out(vlev));
    task automatic end_sim();
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] q);
        logic ok;
        host_u.xfer(w, a, d, s, q, ok);
        chk(ok, 1'b1);
        if (!ok) end_sim();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hf, q);
        repeat (3) @(posedge sys_clk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hf, q);
        chk(q, exp);
    endtask
    task automatic t_reset();
        repeat (5) @(posedge sys_clk_in);
        chk({bias, unity, rdy, brg, smute, dmute, se, gext, vact, vlev}, 14'h1f);
        rst_n_in <= 1'b1;
        rd(acm_pkg::CTRL_OFF, 32'h0);
        rd(acm_pkg::VOL_OFF, 32'h0);
        rd(8'h0c, 32'h0);
    endtask
    task automatic t_power();
        int n;
        logic [31:0] q;
        bus(1'b1, acm_pkg::CTRL_OFF, 32'h1, 4'he, q);
        repeat (6) @(posedge sys_clk_in);
        chk(bias, 1'b0);
        wr(acm_pkg::CTRL_OFF, 32'h1);
        n = 0;
        while (unity !== 1'b1 && n < 20) begin
            @(posedge sys_clk_in);
            n++;
        end
        chk({bias, rdy}, 2'b10);
        n = 0;
        while (unity === 1'b1 && n < 100) begin
            @(posedge sys_clk_in);
            n++;
        end
        chk(n, SETTLE_N);
        #1 chk({unity, rdy}, 2'b01);
        rd(acm_pkg::STAT_OFF, 32'h21);
    endtask
    task automatic t_gain();
        wr(acm_pkg::VOL_OFF, 32'h0a);
        chk({vact, gext, vlev}, 7'h1f);
        wr(acm_pkg::CTRL_OFF, 32'h05);
        chk({vact, gext, vlev}, 7'h4a);
        wr(acm_pkg::CTRL_OFF, 32'h09);
        chk({vact, gext, vlev}, 7'h3f);
    endtask
    task automatic t_mute();
        wr(acm_pkg::CTRL_OFF, 32'h03);
        chk({brg, smute, dmute}, 3'b011);
        @(posedge sys_clk_in) alert <= 1'b1;
        repeat (8) @(posedge sys_clk_in);
        chk({brg, smute, dmute}, 3'b101);
        rd(acm_pkg::STAT_OFF, 32'h25);
        alert <= 1'b0;
        wr(acm_pkg::CTRL_OFF, 32'h01);
        repeat (6) @(posedge sys_clk_in);
        chk({brg, smute, dmute}, 3'b100);
    endtask
    task automatic t_hp();
        wr(acm_pkg::CTRL_OFF, 32'h11);
        chk(se, 1'b1);
        wr(acm_pkg::CTRL_OFF, 32'h01);
        chk(se, 1'b0);
        @(posedge sys_clk_in) hp <= 1'b1;
        repeat (8) @(posedge sys_clk_in);
        chk(se, 1'b1);
        rd(acm_pkg::STAT_OFF, 32'h39);
        hp <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
        chk(se, 1'b0);
        wr(acm_pkg::CTRL_OFF, 32'h00);
        chk({bias, rdy}, 2'b00);
    endtask
    task automatic t_rereset();
        wr(acm_pkg::VOL_OFF, 32'h15);
        wr(acm_pkg::CTRL_OFF, 32'h1f);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        chk({bias, unity, rdy, brg, smute, dmute, se, gext, vact, vlev}, 14'h1f);
        rst_n_in <= 1'b1;
        rd(acm_pkg::CTRL_OFF, 32'h0);
        rd(acm_pkg::VOL_OFF, 32'h0);
        repeat (4) @(posedge sys_clk_in);
        chk({bias, rdy}, 2'b00);
    endtask
    initial begin
        #1;
        t_reset();
        t_power();
        t_gain();
        t_mute();
        t_hp();
        t_rereset();
        end_sim();
    end
    initial begin
        #200000;
        err_count++;
        end_sim();
    end
endmodule
